// >>> shared/aicc_pkg.sv
// ==========================================================
// Shared constants for the calibration clear and alarm block
package aicc_pkg;
    // I/O word addressing
    localparam logic [15:0] AICC_BASE_WORD = 16'h07D0;
    localparam logic [15:0] AICC_UNIT_STEP = 16'h000A;
    localparam logic [15:0] AICC_OFS_CTL = 16'h0001;
    localparam logic [15:0] AICC_OFS_MON = 16'h0008;
    localparam logic [15:0] AICC_OFS_W9 = 16'h0009;
    localparam logic [15:0] AICC_OFS_W18 = 16'h0012;
    localparam logic [15:0] AICC_OFS_W19 = 16'h0013;
    // Control word fields
    localparam int AICC_CTL_SET_BIT = 4;
    localparam int AICC_CTL_CLR_BIT = 5;
    localparam logic [15:0] AICC_CTL_RESET = 16'h0000;
    // Alarm flag positions
    localparam int AICC_ALM_ADJ = 15;
    localparam int AICC_ALM_NVM = 14;
    localparam int AICC_ALM_INUM = 13;
    localparam int AICC_ALM_RANGE = 12;
    localparam int AICC_ALM_MEAN = 11;
    localparam int AICC_ALM_SCALE = 8;
    localparam logic [15:0] AICC_WORD_RESET = 16'h0000;
    // Timing
    localparam int AICC_CLK_MHZ = 125;
    localparam int AICC_LINK_TIMEOUT_US = 1000;
    localparam int AICC_LINK_TIMEOUT_CYC = AICC_LINK_TIMEOUT_US * AICC_CLK_MHZ;
    localparam int AICC_FLASH_HALF_MS = 250;
    localparam int AICC_FLASH_HALF_CYC = AICC_FLASH_HALF_MS * 1000 * AICC_CLK_MHZ;
    // Nonvolatile clear sequencer
    typedef enum logic [2:0] {
        AICC_ST_IDLE = 3'b001,
        AICC_ST_REQ = 3'b010,
        AICC_ST_WAIT = 3'b100
    } aicc_nvm_st_t;
    // Absolute word index of a unit word
    function automatic logic [15:0] aicc_word(input logic [15:0] base,
                                              input logic [15:0] ofs);
        aicc_word = base + ofs;
    endfunction : aicc_word
endpackage : aicc_pkg

// >>> shared/aicc_disc_if.sv
`timescale 1ns/1ps
// ==========================================================
// Disconnection sense path between top and filter
interface aicc_disc_if;
    logic [15:0] raw;
    logic [15:0] det;
    modport filt (input raw, output det);
    modport user (output raw, input det);
endinterface : aicc_disc_if

// >>> verilog/aicc_disc_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Three-stage sync of open-wire sense, accepted on agreement
module aicc_disc_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Sense path
    aicc_disc_if.filt dif
);
    logic [15:0] s1_ff;
    logic [15:0] s2_ff;
    logic [15:0] s3_ff;
    logic [15:0] det_ff;

    // Synchroniser chain; stage one feeds stage two, stage two feeds stage three
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_ff <= 16'h0000;
            s2_ff <= 16'h0000;
            s3_ff <= 16'h0000;
        end else begin
            s1_ff <= dif.raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Bit changes only where stages two and three agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            det_ff <= 16'h0000;
        end else begin
            det_ff <= (s2_ff & s3_ff) | (det_ff & (s2_ff | s3_ff));
        end
    end

    assign dif.det = det_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_agree;
        (s2_ff == s3_ff) |=> (det_ff == $past(s2_ff));
    endproperty
    a_agree: assert property (p_agree) else $error("open-wire filter ignored agreement");
endmodule : aicc_disc_sync

// >>> verilog/aicc_unit.sv
`timescale 1ns/1ps
// ==========================================================
// Calibration clear, indicators and alarm words
// Operation
// - While clear bit is on, monitor word n+8 reads 0000.
// - Set bit rising with clear on restores default calibration in nonvolatile store.
// - Run lamp lit in normal mode, dark once CPU exchange stops.
// - Own errors light unit fault lamp and set matching flag.
// - Calibration lamp flashes in adjustment mode, dark otherwise.
// - Host link fault lamp lit on CPU exchange error.
// - Open-wire detection only for inputs on 1-5 V or 4-20 mA.
// - Eight-input word n+9: open-wire flags low byte, alarms high byte.
// - Sixteen-input: n+18 open-wire flags, n+19 alarms high, low byte zero.
// - Alarm 15 in adjustment mode; alarm 14 on nonvolatile error there.
// - Adjustment mode: alarm 13 bad input number, 12 input out of window.
// - Alarm 11 mean setting error; sixteen-input alarm 08 scaling error.
// - Open-wire input has its conversion data forced to 0000.
// - Normal-mode errors light fault and run lamps; flags self-clear.
// - Base word index is 2000 plus ten times unit number.
module aicc_unit import aicc_pkg::*; #(
    parameter int LINK_TIMEOUT_CYC = AICC_LINK_TIMEOUT_CYC,
    parameter int FLASH_HALF_CYC = AICC_FLASH_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Straps, caught after reset release
    input wire logic [6:0] unit_no,
    input wire logic wide_sel,
    input wire logic adj_mode_sel,
    // I/O refresh area access from the controller
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    output logic io_rvalid,
    input wire logic host_bus_err,
    // Converter side
    input wire logic [15:0] mon_data,
    input wire logic conv_valid,
    input wire logic [3:0] conv_ch,
    input wire logic [15:0] conv_data,
    output logic conv_q_valid,
    output logic [3:0] conv_q_ch,
    output logic [15:0] conv_q_data,
    // Input configuration and sensing
    input wire logic [15:0] range_live_zero,
    input wire logic [15:0] open_wire_pin,
    // Error conditions from the adjust and setup logic
    input wire logic inum_err,
    input wire logic adj_range_err,
    input wire logic mean_cfg_err,
    input wire logic scale_cfg_err,
    // Nonvolatile store
    output logic nvm_clear_req,
    input wire logic nvm_busy,
    input wire logic nvm_err,
    // Front panel
    output logic run_lamp,
    output logic unit_fault_lamp,
    output logic calibration_lamp,
    output logic host_link_fault_lamp
);
    aicc_disc_if dif ();
    aicc_nvm_st_t st_ff;
    logic strap_done_ff;
    logic [15:0] base_ff;
    logic wide_ff;
    logic adj_ff;
    logic [15:0] ctl_ff;
    logic set_prev_ff;
    logic nvm_alm_ff;
    logic [15:0] rdata_ff;
    logic rvalid_ff;
    logic [31:0] idle_cnt_ff;
    logic link_up_ff;
    logic [31:0] flash_cnt_ff;
    logic flash_ff;
    logic run_ff;
    logic fault_ff;
    logic cal_ff;
    logic hfault_ff;
    logic nvm_req_ff;
    logic cq_valid_ff;
    logic [3:0] cq_ch_ff;
    logic [15:0] cq_data_ff;
    logic [15:0] disc;
    logic [15:0] alarms;
    logic [15:0] word9;
    logic set_rise;
    logic acc;

    // ==========================================================
    // Open-wire sensing
    assign dif.raw = open_wire_pin;
    aicc_disc_sync u_disc (
        .ref_clk(ref_clk),
        .rst(rst),
        .dif(dif)
    );

    // Flags only for live-zero ranges; narrow unit sees eight inputs
    always_comb begin
        disc = dif.det & range_live_zero;
        if (!wide_ff) begin
            disc[15:8] = 8'h00;
        end
    end

    // ==========================================================
    // Straps: unit number, variant and mode, caught once
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_done_ff <= 1'b0;
            base_ff <= AICC_BASE_WORD;
            wide_ff <= 1'b0;
            adj_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            base_ff <= AICC_BASE_WORD + AICC_UNIT_STEP * {9'h000, unit_no};
            wide_ff <= wide_sel;
            adj_ff <= adj_mode_sel;
        end
    end

    // ==========================================================
    // Control word and set-bit edge
    assign set_rise = ctl_ff[AICC_CTL_SET_BIT] & ~set_prev_ff;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_ff <= AICC_CTL_RESET;
            set_prev_ff <= 1'b0;
        end else begin
            if (io_wr && io_addr == aicc_word(base_ff, AICC_OFS_CTL)) begin
                ctl_ff <= io_wdata;
            end
            set_prev_ff <= ctl_ff[AICC_CTL_SET_BIT];
        end
    end

    // Clear sequencer; edges arriving while busy are dropped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= AICC_ST_IDLE;
            nvm_req_ff <= 1'b0;
        end else begin
            nvm_req_ff <= 1'b0;
            unique case (st_ff)
                AICC_ST_IDLE: begin
                    if (set_rise && ctl_ff[AICC_CTL_CLR_BIT]) begin
                        st_ff <= AICC_ST_REQ;
                        nvm_req_ff <= 1'b1;
                    end
                end
                AICC_ST_REQ: begin
                    st_ff <= AICC_ST_WAIT;
                end
                AICC_ST_WAIT: begin
                    if (!nvm_busy) begin
                        st_ff <= AICC_ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= AICC_ST_IDLE;
                end
            endcase
        end
    end

    // Write error stays until the next set-bit rise; a new error wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nvm_alm_ff <= 1'b0;
        end else if (nvm_err && adj_ff) begin
            nvm_alm_ff <= 1'b1;
        end else if (set_rise) begin
            nvm_alm_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Alarm flags other than 14 follow their conditions, so they self-clear; 14 holds until a set-bit rise
    always_comb begin
        alarms = AICC_WORD_RESET;
        alarms[AICC_ALM_ADJ] = adj_ff;
        alarms[AICC_ALM_NVM] = nvm_alm_ff & adj_ff;
        alarms[AICC_ALM_INUM] = inum_err & adj_ff;
        alarms[AICC_ALM_RANGE] = adj_range_err & adj_ff;
        alarms[AICC_ALM_MEAN] = mean_cfg_err;
        alarms[AICC_ALM_SCALE] = scale_cfg_err & wide_ff;
    end

    assign word9 = {alarms[15:8], disc[7:0]};

    // ==========================================================
    // Word reads, one cycle latency; unmapped words read zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= AICC_WORD_RESET;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= io_rd;
            rdata_ff <= AICC_WORD_RESET;
            if (io_rd) begin
                if (io_addr == aicc_word(base_ff, AICC_OFS_CTL)) begin
                    rdata_ff <= ctl_ff;
                end else if (io_addr == aicc_word(base_ff, AICC_OFS_MON)) begin
                    rdata_ff <= ctl_ff[AICC_CTL_CLR_BIT] ? 16'h0000 : mon_data;
                end else if (!wide_ff && io_addr == aicc_word(base_ff, AICC_OFS_W9)) begin
                    rdata_ff <= word9;
                end else if (wide_ff && io_addr == aicc_word(base_ff, AICC_OFS_W18)) begin
                    rdata_ff <= disc;
                end else if (wide_ff && io_addr == aicc_word(base_ff, AICC_OFS_W19)) begin
                    rdata_ff <= {alarms[15:8], 8'h00};
                end
            end
        end
    end

    // ==========================================================
    // Conversion data pass with open-wire forcing
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cq_valid_ff <= 1'b0;
            cq_ch_ff <= 4'h0;
            cq_data_ff <= 16'h0000;
        end else begin
            cq_valid_ff <= conv_valid;
            cq_ch_ff <= conv_ch;
            cq_data_ff <= disc[conv_ch] ? 16'h0000 : conv_data;
        end
    end

    // ==========================================================
    // Refresh watchdog: no access for the timeout means link lost
    assign acc = io_wr | io_rd;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            idle_cnt_ff <= 32'h0000_0000;
            link_up_ff <= 1'b0;
        end else if (acc) begin
            idle_cnt_ff <= 32'h0000_0000;
            link_up_ff <= 1'b1;
        end else if (idle_cnt_ff >= LINK_TIMEOUT_CYC[31:0] - 32'h0000_0001) begin
            link_up_ff <= 1'b0;
        end else begin
            idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
        end
    end

    // Flash timebase, free running
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flash_cnt_ff <= 32'h0000_0000;
            flash_ff <= 1'b0;
        end else if (flash_cnt_ff >= FLASH_HALF_CYC[31:0] - 32'h0000_0001) begin
            flash_cnt_ff <= 32'h0000_0000;
            flash_ff <= ~flash_ff;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Lamps, registered so panel drive is glitch free
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_ff <= 1'b0;
            fault_ff <= 1'b0;
            cal_ff <= 1'b0;
            hfault_ff <= 1'b0;
        end else begin
            run_ff <= ~adj_ff & link_up_ff & ~host_bus_err;
            fault_ff <= (|alarms[14:8]) | (|disc);
            cal_ff <= adj_ff & flash_ff;
            hfault_ff <= host_bus_err;
        end
    end

    assign io_rdata = rdata_ff;
    assign io_rvalid = rvalid_ff;
    assign conv_q_valid = cq_valid_ff;
    assign conv_q_ch = cq_ch_ff;
    assign conv_q_data = cq_data_ff;
    assign nvm_clear_req = nvm_req_ff;
    assign run_lamp = run_ff;
    assign unit_fault_lamp = fault_ff;
    assign calibration_lamp = cal_ff;
    assign host_link_fault_lamp = hfault_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_clr_set;
        ctl_ff[AICC_CTL_CLR_BIT] && set_rise && st_ff == AICC_ST_IDLE;
    endsequence
    sequence s_one_req;
        nvm_clear_req ##1 !nvm_clear_req;
    endsequence
    property p_clear;
        s_clr_set |=> s_one_req;
    endproperty
    a_clear: assert property (p_clear) else $error("clear request missing");
    property p_once;
        nvm_clear_req |=> !nvm_clear_req [*2];
    endproperty
    a_once: assert property (p_once) else $error("repeat clear request");
    property p_mon;
        io_rd && ctl_ff[AICC_CTL_CLR_BIT] && io_addr == aicc_word(base_ff, AICC_OFS_MON)
            |=> io_rvalid && io_rdata == 16'h0000;
    endproperty
    a_mon: assert property (p_mon) else $error("monitor not zero in clear");
    property p_run;
        !link_up_ff |=> !run_lamp;
    endproperty
    a_run: assert property (p_run) else $error("run lamp lit without link");
    property p_fault;
        (disc != 16'h0000) |=> unit_fault_lamp;
    endproperty
    a_fault: assert property (p_fault) else $error("fault lamp dark on error");
    property p_cal;
        !adj_ff |=> !calibration_lamp;
    endproperty
    a_cal: assert property (p_cal) else $error("calibration lamp lit outside adjust");
    property p_host;
        host_bus_err |=> host_link_fault_lamp && !run_lamp;
    endproperty
    a_host: assert property (p_host) else $error("host fault lamp dark");
    property p_range;
        (disc & ~range_live_zero) == 16'h0000;
    endproperty
    a_range: assert property (p_range) else $error("open wire on wrong range");
    property p_zero;
        conv_valid && disc[conv_ch] |=> conv_q_valid && conv_q_data == 16'h0000;
    endproperty
    a_zero: assert property (p_zero) else $error("open input not forced");
    property p_base;
        strap_done_ff |-> base_ff == AICC_BASE_WORD + AICC_UNIT_STEP * {9'h000, $past(unit_no)}
            || $stable(strap_done_ff);
    endproperty
    a_base: assert property (p_base) else $error("base word index wrong");
endmodule : aicc_unit

// >>> tb/aicc_nvm_model.sv
`timescale 1ns/1ps
// ==========================================================
// Nonvolatile store stand-in
module aicc_nvm_model #(
    parameter int BUSY_CYC = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Store port
    input wire logic nvm_clear_req,
    input wire logic fail,
    output logic nvm_busy,
    output logic nvm_err
);
    int cnt_ff;
    // Busy after each clear; an error pulse at its end only when told to fail
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 0;
            nvm_err <= 1'b0;
        end else begin
            nvm_err <= (cnt_ff == 1) && fail;
            if (nvm_clear_req) begin
                cnt_ff <= BUSY_CYC;
            end else if (cnt_ff != 0) begin
                cnt_ff <= cnt_ff - 1;
            end
        end
    end
    // Busy level follows the count
    assign nvm_busy = (cnt_ff != 0);
endmodule : aicc_nvm_model

// >>> tb/aicc_unit_test.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the calibration clear and alarm block
module aicc_unit_test;
    localparam int LTO = 20;
    localparam int FHC = 4;
    logic ref_clk, rst, wide_sel, adj_mode_sel, io_wr, io_rd, io_rvalid, host_bus_err, b;
    logic [6:0] unit_no;
    logic [15:0] io_addr, io_wdata, io_rdata, mon_data, conv_data, conv_q_data, base, lf;
    logic [15:0] range_live_zero, open_wire_pin;
    logic [3:0] conv_ch, conv_q_ch;
    logic conv_valid, conv_q_valid, inum_err, adj_range_err, mean_cfg_err, scale_cfg_err;
    logic nvm_clear_req, nvm_busy, nvm_err, fail;
    logic run_lamp, unit_fault_lamp, calibration_lamp, host_link_fault_lamp;
    logic [15:0] rq[$];
    logic [15:0] cq[$];
    logic [3:0] hq[$];
    int mismatches, n_tests, pulses, trn;

    // ==========================================================
    // Design and store
    aicc_unit #(.LINK_TIMEOUT_CYC(LTO), .FLASH_HALF_CYC(FHC)) uut (
        .ref_clk, .rst, .unit_no, .wide_sel, .adj_mode_sel, .io_wr, .io_rd, .io_addr,
        .io_wdata, .io_rdata, .io_rvalid, .host_bus_err, .mon_data, .conv_valid, .conv_ch,
        .conv_data, .conv_q_valid, .conv_q_ch, .conv_q_data, .range_live_zero,
        .open_wire_pin, .inum_err, .adj_range_err, .mean_cfg_err, .scale_cfg_err,
        .nvm_clear_req, .nvm_busy, .nvm_err, .run_lamp, .unit_fault_lamp,
        .calibration_lamp, .host_link_fault_lamp
    );
    aicc_nvm_model #(.BUSY_CYC(3)) nvm (
        .ref_clk, .rst, .nvm_clear_req, .fail, .nvm_busy, .nvm_err
    );

    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        idle(1);
        io_wr = 1'b1;
        io_addr = base + a;
        io_wdata = d;
        idle(1);
        io_wr = 1'b0;
    endtask : wr

    // Expected word queued when the read is issued
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        idle(1);
        rq.push_back(e);
        io_rd = 1'b1;
        io_addr = base + a;
        idle(1);
        io_rd = 1'b0;
    endtask : rd

    task automatic cv(input logic [3:0] c, input logic [15:0] d, input logic [15:0] e);
        idle(1);
        cq.push_back(e);
        hq.push_back(c);
        conv_valid = 1'b1;
        conv_ch = c;
        conv_data = d;
        idle(1);
        conv_valid = 1'b0;
    endtask : cv

    // Lamps as {run, fault, calibration, host}, masked where flashing
    // One edge after the cause reaches the lamp register, so wait one full cycle
    task automatic lamps(input logic [3:0] e, input logic [3:0] m);
        idle(1);
        chk({12'h000, e & m}, {12'h000, m & {run_lamp, unit_fault_lamp,
            calibration_lamp, host_link_fault_lamp}});
    endtask : lamps

    task automatic do_reset(input logic w, input logic a);
        rst = 1'b1;
        wide_sel = w;
        adj_mode_sel = a;
        lf = lfsr(lf);
        unit_no = lf[6:0];
        base = 16'h07D0 + 16'(unit_no) * 16'h000A;
        idle(5);
        lamps(4'b0000, 4'hF);
        rst = 1'b0;
        idle(2);
    endtask : do_reset

    task automatic conclude;
        if (rq.size() != 0 || cq.size() != 0 || hq.size() != 0) begin
            mismatches++;
        end
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // Clock, pulse count, watchdog
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Restore requests seen at the store port, counted mid-cycle to avoid edge races
    always @(negedge ref_clk) begin
        if (nvm_clear_req === 1'b1) begin
            pulses++;
        end
    end

    // Stops a hang well past the expected run length
    initial begin
        #200000;
        mismatches++;
        conclude();
    end

    // Results meet the oldest note; settled values looked at on the falling edge
    always @(negedge ref_clk) begin
        if (io_rvalid === 1'b1) begin
            chk(rq.size() != 0 ? rq.pop_front() : 16'hxxxx, io_rdata);
        end
        if (conv_q_valid === 1'b1) begin
            chk(cq.size() != 0 ? cq.pop_front() : 16'hxxxx, conv_q_data);
            chk({12'h000, hq.size() != 0 ? hq.pop_front() : 4'hx}, {12'h000, conv_q_ch});
        end
    end

    // ==========================================================
    // Scenarios
    initial begin
        lf = 16'h004E;
        {mismatches, n_tests, pulses, trn} = '0;
        {io_wr, io_rd, host_bus_err, conv_valid, inum_err, adj_range_err, b} = '0;
        {mean_cfg_err, scale_cfg_err, fail, conv_ch, unit_no, base} = '0;
        {io_addr, io_wdata, mon_data, conv_data, range_live_zero, open_wire_pin} = '0;
        // Eight-input unit in normal mode
        do_reset(1'b0, 1'b0);
        rd(16'h0002, 16'h0000);
        lamps(4'b1000, 4'hF);
        host_bus_err = 1'b1;
        idle(2);
        lamps(4'b0001, 4'hF);
        host_bus_err = 1'b0;
        lf = lfsr(lf);
        mon_data = lf;
        rd(16'h0008, lf);
        wr(16'h0001, 16'h0020);
        rd(16'h0008, 16'h0000);
        rd(16'h0001, 16'h0020);
        wr(16'h0001, 16'h0030);
        idle(12);
        chk(16'h0001, 16'(pulses));
        wr(16'h0001, 16'h0020);
        wr(16'h0001, 16'h0030);
        idle(6);
        chk(16'h0002, 16'(pulses));
        wr(16'h0001, 16'h0020);
        wr(16'h0001, 16'h0000);
        wr(16'h0001, 16'h0010);
        idle(6);
        chk(16'h0002, 16'(pulses));
        wr(16'h0001, 16'h0000);
        // Open wires on random inputs, input 0 watched, input 1 not watched
        lf = lfsr(lf);
        range_live_zero = (lf | 16'h0001) & 16'hFFFD;
        lf = lfsr(lf);
        open_wire_pin = lf | 16'h0003;
        mean_cfg_err = 1'b1;
        scale_cfg_err = 1'b1;
        idle(8);
        rd(16'h0009, {8'h08, range_live_zero[7:0] & open_wire_pin[7:0]});
        lamps(4'b1100, 4'hF);
        lf = lfsr(lf);
        cv(4'h0, lf, 16'h0000);
        cv(4'h1, lf, lf);
        open_wire_pin = 16'h0000;
        mean_cfg_err = 1'b0;
        scale_cfg_err = 1'b0;
        idle(8);
        rd(16'h0009, 16'h0000);
        rd(16'h0012, 16'h0000);
        lamps(4'b1000, 4'hF);
        idle(30);
        lamps(4'b0000, 4'hF);
        // Sixteen-input unit in adjustment mode; set bit is off here
        do_reset(1'b1, 1'b1);
        rd(16'h0013, 16'h8000);
        lamps(4'b0000, 4'hD);
        inum_err = 1'b1;
        adj_range_err = 1'b1;
        scale_cfg_err = 1'b1;
        idle(2);
        rd(16'h0013, 16'hB100);
        lamps(4'b0100, 4'hD);
        {inum_err, adj_range_err, scale_cfg_err} = '0;
        range_live_zero = 16'hFFFF;
        lf = lfsr(lf);
        open_wire_pin = lf;
        idle(8);
        rd(16'h0012, lf);
        rd(16'h0013, 16'h8000);
        open_wire_pin = 16'h0000;
        idle(1);
        b = calibration_lamp;
        repeat (32) begin
            idle(1);
            if (calibration_lamp !== b) begin
                trn++;
            end
            b = calibration_lamp;
        end
        chk(16'h0001, 16'(trn >= 6 && trn <= 8));
        fail = 1'b1;
        wr(16'h0001, 16'h0020);
        wr(16'h0001, 16'h0030);
        idle(8);
        rd(16'h0013, 16'hC000);
        fail = 1'b0;
        wr(16'h0001, 16'h0020);
        wr(16'h0001, 16'h0030);
        wr(16'h0001, 16'h0020);
        idle(8);
        rd(16'h0013, 16'h8000);
        wr(16'h0001, 16'h0000);
        idle(4);
        conclude();
    end
endmodule : aicc_unit_test
